// ### logic/can_ctrl_pkg.sv
// Contract
// - Abort-all bit tells every transmit buffer to abort; hardware clears it when done.
// - Requested mode codes: 000 normal, 001 disable, 010 loopback, 011 listen, 100 config, 111 all.
// - Read-only current mode field reports the mode in force, same encoding.
// - Capture enabled stores timer on valid reception; disabled stops the timer.
// - Clearing enable lets the current transaction finish; busy bit shows when off.
// - Nine interrupt sources: invalid, wake, bus error, system error, overflow, mode, timer, rx, tx.
// - Each source has an enable in the upper half; request only while enabled.
// - Flags sit in the lower half mirroring enables; invalid message sets its flag.
// - System error flag clears only by turning the module off and on again.
// - Sixteen FIFOs each own a user-address pointer and a message-index pointer.
// - Transmit FIFO user address returns the head, where software writes next.
// - Receive FIFO user address returns the tail, where software reads next.
// - The two low bits of every user address always read as zero.
// - Transmit FIFO message index returns the slot transmitted next.
// - Receive FIFO message index returns the slot where the next message is stored.
package can_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_INTERRUPT = 8'h04;
    localparam logic [7:0] OFS_DIRECTION = 8'h08;
    localparam logic [7:0] OFS_ADVANCE   = 8'h0C;
    localparam logic [1:0] PAGE_UA       = 2'h1;
    localparam logic [1:0] PAGE_CI       = 2'h2;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int BIT_ABORT = 27;
    localparam int REQ_LSB   = 24;
    localparam int CUR_LSB   = 21;
    localparam int BIT_CAP   = 20;
    localparam int BIT_ON    = 15;
    localparam int BIT_STOP  = 13;
    localparam int BIT_BUSY  = 11;
    localparam int FILTER_W  = 5;

    // ------------------------------------------------------------------
    // Interrupt register fields
    // ------------------------------------------------------------------
    localparam int EN_LSB        = 16;
    localparam int FL_TX_BUF     = 0;
    localparam int FL_RX_BUF     = 1;
    localparam int FL_TIMER      = 2;
    localparam int FL_MODE       = 3;
    localparam int FL_RX_OVF     = 11;
    localparam int FL_SYS_ERR    = 12;
    localparam int FL_BUS_ERR    = 13;
    localparam int FL_WAKE       = 14;
    localparam int FL_INVALID    = 15;
    localparam logic [15:0] FLAG_MASK = 16'hF80F;

    // ------------------------------------------------------------------
    // Modes and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_NORMAL   = 3'h0;
    localparam logic [2:0] MODE_DISABLE  = 3'h1;
    localparam logic [2:0] MODE_LOOPBACK = 3'h2;
    localparam logic [2:0] MODE_LISTEN   = 3'h3;
    localparam logic [2:0] MODE_CONFIG   = 3'h4;
    localparam logic [2:0] MODE_RSVD_A   = 3'h5;
    localparam logic [2:0] MODE_RSVD_B   = 3'h6;
    localparam logic [2:0] MODE_LISTEN_ALL = 3'h7;
    localparam logic [2:0] MODE_RESET    = MODE_CONFIG;

    // ------------------------------------------------------------------
    // FIFO geometry and time-stamp width
    // ------------------------------------------------------------------
    localparam int NUM_FIFO  = 16;
    localparam int IDX_W     = 5;
    localparam int MSG_SHIFT = 4;
    localparam int TS_W      = 16;

    typedef struct packed {
        logic invalid_msg;
        logic bus_wake;
        logic bus_error;
        logic system_error;
        logic rx_overflow;
    } can_events_t;

    typedef struct packed {
        logic       tx_done;
        logic       rx_store;
        logic [3:0] fifo_sel;
        logic       bus_idle;
        logic       tx_all_idle;
    } can_side_t;

    typedef struct packed {
        logic                           abort_all_tx;
        logic [2:0]                     requested_op_mode;
        logic [2:0]                     current_op_mode;
        logic                           rx_timestamp_capture_en;
        logic                           module_on;
        logic                           stop_in_idle;
        logic                           module_busy_status;
        logic [FILTER_W-1:0]            net_filter_bit_count;
        logic [15:0]                    irq_en;
        logic [15:0]                    irq_flag;
        logic [NUM_FIFO-1:0]            fifo_direction_tx;
        logic [NUM_FIFO-1:0][IDX_W-1:0] user_slot;
        logic [NUM_FIFO-1:0][IDX_W-1:0] can_slot;
        logic [TS_W-1:0]                rx_timestamp_timer;
        logic [TS_W-1:0]                stamp;
        logic                           stamp_valid;
        logic                           off_seen;
        logic [31:0]                    rdata;
        logic                           irq;
    } ctrl_state_t;

endpackage : can_ctrl_pkg

// ### logic/can_mode_irq_fifo_pointer_logic.sv
module can_mode_irq_fifo_pointer_logic #(
    parameter logic [31:0] FIFO_RAM_BASE = 32'h0000_0000
) (
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          srst_in,
    // Register port
    input  wire logic [7:0]                    addr_in,
    input  wire logic [31:0]                   wdata_in,
    input  wire logic                          wr_in,
    input  wire logic                          rd_in,
    output logic      [31:0]                   rdata_out,
    // CAN engine side
    input  wire can_ctrl_pkg::can_events_t     events_in,
    input  wire can_ctrl_pkg::can_side_t       can_in,
    output logic                               abort_tx_out,
    output logic      [2:0]                    op_mode_out,
    output logic                               module_on_out,
    output logic      [can_ctrl_pkg::TS_W-1:0] rx_stamp_out,
    output logic                               rx_stamp_valid_out,
    // Interrupt
    output logic                               irq_out
);

    can_ctrl_pkg::ctrl_state_t st;
    can_ctrl_pkg::ctrl_state_t next_st;

    logic [15:0] set_flag;
    logic [15:0] clr_flag;
    logic [31:0] read_word;
    logic [3:0]  sel;
    logic        req_valid;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        set_flag = '0;
        clr_flag = '0;
        read_word = '0;
        sel = addr_in[5:2];
        req_valid = (st.requested_op_mode != can_ctrl_pkg::MODE_RSVD_A) &&
                    (st.requested_op_mode != can_ctrl_pkg::MODE_RSVD_B);

        // Event sources feed sticky flags.
        set_flag[can_ctrl_pkg::FL_INVALID] = events_in.invalid_msg;
        set_flag[can_ctrl_pkg::FL_WAKE]    = events_in.bus_wake;
        set_flag[can_ctrl_pkg::FL_BUS_ERR] = events_in.bus_error;
        set_flag[can_ctrl_pkg::FL_SYS_ERR] = events_in.system_error;
        set_flag[can_ctrl_pkg::FL_RX_OVF]  = events_in.rx_overflow;
        set_flag[can_ctrl_pkg::FL_RX_BUF]  = can_in.rx_store;
        set_flag[can_ctrl_pkg::FL_TX_BUF]  = can_in.tx_done;

        // Abort clears itself once the transmit side reports all idle.
        if (st.abort_all_tx && can_in.tx_all_idle) begin
            next_st.abort_all_tx = 1'b0;
        end

        // Mode switches take effect only on an idle bus.
        if (req_valid && can_in.bus_idle &&
            (st.current_op_mode != st.requested_op_mode)) begin
            next_st.current_op_mode = st.requested_op_mode;
            set_flag[can_ctrl_pkg::FL_MODE] = 1'b1;
        end

        // Turning off waits for the transaction in progress to end.
        if (st.module_on) begin
            next_st.module_busy_status = 1'b1;
        end else if (can_in.bus_idle) begin
            next_st.module_busy_status = 1'b0;
            next_st.off_seen = st.module_busy_status | st.off_seen;
        end

        // The time-stamp timer runs only while capture is enabled.
        if (st.rx_timestamp_capture_en && st.module_busy_status) begin
            next_st.rx_timestamp_timer =
                st.rx_timestamp_timer + {{(can_ctrl_pkg::TS_W-1){1'b0}}, 1'b1};
            if (&st.rx_timestamp_timer) begin
                set_flag[can_ctrl_pkg::FL_TIMER] = 1'b1;
            end
        end
        next_st.stamp_valid = 1'b0;
        if (can_in.rx_store && st.rx_timestamp_capture_en) begin
            next_st.stamp = st.rx_timestamp_timer;
            next_st.stamp_valid = 1'b1;
        end

        // CAN side advances the engine pointer of the selected FIFO.
        for (int i = 0; i < can_ctrl_pkg::NUM_FIFO; i++) begin
            if (can_in.fifo_sel == 4'(i) &&
                ((st.fifo_direction_tx[i] && can_in.tx_done) ||
                 (!st.fifo_direction_tx[i] && can_in.rx_store))) begin
                next_st.can_slot[i] = st.can_slot[i] + 5'h01;
            end
        end

        // Register writes.
        if (wr_in) begin
            case (addr_in)
                can_ctrl_pkg::OFS_CONTROL: begin
                    if (wdata_in[can_ctrl_pkg::BIT_ABORT]) begin
                        next_st.abort_all_tx = 1'b1;
                    end
                    next_st.requested_op_mode =
                        wdata_in[can_ctrl_pkg::REQ_LSB +: 3];
                    next_st.rx_timestamp_capture_en =
                        wdata_in[can_ctrl_pkg::BIT_CAP];
                    next_st.module_on = wdata_in[can_ctrl_pkg::BIT_ON];
                    next_st.stop_in_idle =
                        wdata_in[can_ctrl_pkg::BIT_STOP];
                    next_st.net_filter_bit_count =
                        wdata_in[can_ctrl_pkg::FILTER_W-1:0];
                    if (wdata_in[can_ctrl_pkg::BIT_ON] && !st.module_on &&
                        st.off_seen) begin
                        clr_flag[can_ctrl_pkg::FL_SYS_ERR] = 1'b1;
                        next_st.off_seen = 1'b0;
                    end
                end
                can_ctrl_pkg::OFS_INTERRUPT: begin
                    next_st.irq_en = wdata_in[31:can_ctrl_pkg::EN_LSB] &
                                     can_ctrl_pkg::FLAG_MASK;
                    clr_flag = clr_flag | (wdata_in[15:0] &
                               can_ctrl_pkg::FLAG_MASK);
                    clr_flag[can_ctrl_pkg::FL_SYS_ERR] =
                        ~wdata_in[can_ctrl_pkg::FL_SYS_ERR] & 1'b0;
                end
                can_ctrl_pkg::OFS_DIRECTION: begin
                    next_st.fifo_direction_tx = wdata_in[15:0];
                end
                can_ctrl_pkg::OFS_ADVANCE: begin
                    for (int i = 0; i < can_ctrl_pkg::NUM_FIFO; i++) begin
                        if (wdata_in[i]) begin
                            next_st.user_slot[i] = st.user_slot[i] + 5'h01;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Set wins over clear.
        next_st.irq_flag = ((st.irq_flag & ~clr_flag) | set_flag) &
                           can_ctrl_pkg::FLAG_MASK;
        next_st.irq = |(next_st.irq_flag & next_st.irq_en);

        // Register reads; data stand in the following cycle.
        case (addr_in[7:6])
            2'h0: begin
                case (addr_in)
                    can_ctrl_pkg::OFS_CONTROL: begin
                        read_word[can_ctrl_pkg::BIT_ABORT] = st.abort_all_tx;
                        read_word[can_ctrl_pkg::REQ_LSB +: 3] =
                            st.requested_op_mode;
                        read_word[can_ctrl_pkg::CUR_LSB +: 3] =
                            st.current_op_mode;
                        read_word[can_ctrl_pkg::BIT_CAP] =
                            st.rx_timestamp_capture_en;
                        read_word[can_ctrl_pkg::BIT_ON] = st.module_on;
                        read_word[can_ctrl_pkg::BIT_STOP] = st.stop_in_idle;
                        read_word[can_ctrl_pkg::BIT_BUSY] =
                            st.module_busy_status;
                        read_word[can_ctrl_pkg::FILTER_W-1:0] =
                            st.net_filter_bit_count;
                    end
                    can_ctrl_pkg::OFS_INTERRUPT: begin
                        read_word = {st.irq_en, st.irq_flag};
                    end
                    can_ctrl_pkg::OFS_DIRECTION: begin
                        read_word[15:0] = st.fifo_direction_tx;
                    end
                    default: begin
                        read_word = '0;
                    end
                endcase
            end
            can_ctrl_pkg::PAGE_UA: begin
                // Transmit reads the head, receive the tail.
                read_word = FIFO_RAM_BASE +
                    {19'h0_0000, sel, st.user_slot[sel], 4'h0};
                read_word[1:0] = 2'h0;
            end
            can_ctrl_pkg::PAGE_CI: begin
                read_word[can_ctrl_pkg::IDX_W-1:0] =
                    st.can_slot[sel];
            end
            default: begin
                read_word = '0;
            end
        endcase
        next_st.rdata = rd_in ? read_word : 32'h0000_0000;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st <= '0;
            st.requested_op_mode <= can_ctrl_pkg::MODE_RESET;
            st.current_op_mode <= can_ctrl_pkg::MODE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_out          = st.rdata;
    assign abort_tx_out       = st.abort_all_tx;
    assign op_mode_out        = st.current_op_mode;
    assign module_on_out      = st.module_on;
    assign rx_stamp_out       = st.stamp;
    assign rx_stamp_valid_out = st.stamp_valid;
    assign irq_out            = st.irq;

endmodule // can_mode_irq_fifo_pointer_logic

// ### verification/can_engine_model.sv
module can_engine_model (
    // Clock and reset
    input  wire logic [0:0]          clk_in,
    input  wire logic                srst_in,
    // Requests from the bench, abort from the block
    input  wire logic                abort_tx_in,
    input  wire logic [4:0]          ev_in,
    input  wire logic [1:0]          xfer_in,
    input  wire logic [3:0]          sel_in,
    input  wire logic                hold_in,
    input  wire logic                load_in,
    // Engine side of the block
    output can_ctrl_pkg::can_events_t events_out,
    output can_ctrl_pkg::can_side_t   can_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       pend;
    logic [1:0] cnt;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            events_out <= '0;
            can_out    <= '0;
            pend       <= 1'b0;
            cnt        <= 2'h0;
        end else begin
            events_out       <= ev_in;
            can_out.tx_done  <= xfer_in[1];
            can_out.rx_store <= xfer_in[0];
            // The index is only meaningful beside a pulse.
            can_out.fifo_sel <= |xfer_in ? sel_in : ~can_out.fifo_sel;
            can_out.bus_idle <= !hold_in;
            // Pending frames are dropped four cycles into an abort.
            if (load_in) begin
                pend <= 1'b1;
            end else if (abort_tx_in && cnt == 2'h3) begin
                pend <= 1'b0;
            end
            cnt                 <= abort_tx_in ? cnt + 2'h1 : 2'h0;
            can_out.tx_all_idle <= !pend;
        end
    end
endmodule // can_engine_model

// ### verification/can_mode_irq_fifo_pointer_logic_sva.sv
module can_ctrl_sva (
    input wire logic                      clk_in,
    input wire logic                      srst_in,
    input wire logic [7:0]                addr_in,
    input wire logic [31:0]               wdata_in,
    input wire logic                      wr_in,
    input wire logic                      rd_in,
    input wire logic [31:0]               rdata_out,
    input wire can_ctrl_pkg::can_events_t events_in,
    input wire can_ctrl_pkg::can_side_t   can_in,
    input wire logic                      abort_tx_out,
    input wire logic [2:0]                op_mode_out,
    input wire logic                      module_on_out,
    input wire logic                      rx_stamp_valid_out,
    input wire logic                      irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    logic cw, cr, ir;
    assign cw = wr_in && addr_in == can_ctrl_pkg::OFS_CONTROL;
    assign cr = rd_in && addr_in == can_ctrl_pkg::OFS_CONTROL;
    assign ir = rd_in && addr_in == can_ctrl_pkg::OFS_INTERRUPT;
    property p_abort_set;
        cw && wdata_in[27] |=> abort_tx_out;
    endproperty
    a_abort_set: assert property (p_abort_set)
        else $error("abort request not raised");
    property p_abort_clr;
        abort_tx_out && can_in.tx_all_idle && !(cw && wdata_in[27])
            |=> !abort_tx_out;
    endproperty
    a_abort_clr: assert property (p_abort_clr)
        else $error("abort request not cleared");
    property p_mode_legal;
        op_mode_out != 3'h5 && op_mode_out != 3'h6;
    endproperty
    a_mode_legal: assert property (p_mode_legal)
        else $error("reserved mode in force");
    property p_ctl_read;
        cr |=> rdata_out[23:21] == $past(op_mode_out)
            && rdata_out[27] == $past(abort_tx_out);
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control read disagrees with outputs");
    property p_irq_level;
        ir |=> ((rdata_out[31:16] & rdata_out[15:0]) != 16'h0)
            == $past(irq_out);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level disagrees with register");
    property p_event_flag;
        ir |=> (rdata_out[15:11] & $past(events_in, 2))
            == $past(events_in, 2);
    endproperty
    a_event_flag: assert property (p_event_flag)
        else $error("event did not set its flag");
    property p_ua_align;
        rd_in && addr_in[7:6] == can_ctrl_pkg::PAGE_UA
            |=> rdata_out[1:0] == 2'h0;
    endproperty
    a_ua_align: assert property (p_ua_align)
        else $error("user address not aligned");
    property p_ci_width;
        rd_in && addr_in[7:6] == can_ctrl_pkg::PAGE_CI
            |=> rdata_out[31:5] == 27'h0;
    endproperty
    a_ci_width: assert property (p_ci_width)
        else $error("message index wider than five bits");
    property p_stamp;
        rx_stamp_valid_out |-> $past(can_in.rx_store);
    endproperty
    a_stamp: assert property (p_stamp)
        else $error("stamp without reception");
    property p_on;
        cw |=> module_on_out == $past(wdata_in[15]);
    endproperty
    a_on: assert property (p_on)
        else $error("enable output does not follow write");
    property p_idle_rd;
        !$past(rd_in) |-> rdata_out == 32'h0;
    endproperty
    a_idle_rd: assert property (p_idle_rd)
        else $error("read data outside read slot");
endmodule // can_ctrl_sva
bind can_mode_irq_fifo_pointer_logic can_ctrl_sva chk_u (.clk_in,
    .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .events_in, .can_in, .abort_tx_out, .op_mode_out, .module_on_out,
    .rx_stamp_valid_out, .irq_out);

// ### verification/can_mode_irq_fifo_pointer_logic_tb_top.sv
module can_mode_irq_fifo_pointer_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, srst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out, exp_q[$];
    logic [4:0] ev = 5'h0, eng [16], usr [16];
    logic [1:0] xfer = 2'h0;
    logic [3:0] sel = 4'h0, n;
    logic hold = 1'b0, load = 1'b0, rd_d = 1'b0, rsv;
    logic abort_tx_out, module_on_out, rx_stamp_valid_out, irq_out;
    logic [2:0] op_mode_out, m, c;
    logic [15:0] rx_stamp_out, d, stamps[$];
    can_ctrl_pkg::can_events_t events_in;
    can_ctrl_pkg::can_side_t can_in;
    int fails = 0, comparisons = 0, seed, k;
    logic [2:0] modes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h5, 3'h6};
    can_mode_irq_fifo_pointer_logic dut_u (.clk_in, .srst_in, .addr_in,
        .wdata_in, .wr_in, .rd_in, .rdata_out, .events_in, .can_in,
        .abort_tx_out, .op_mode_out, .module_on_out, .rx_stamp_out,
        .rx_stamp_valid_out, .irq_out);
    can_engine_model eng_u (.clk_in, .srst_in, .abort_tx_in(abort_tx_out),
        .ev_in(ev), .xfer_in(xfer), .sel_in(sel), .hold_in(hold),
        .load_in(load), .events_out(events_in), .can_out(can_in));
    always #10 clk_in = ~clk_in;
    // ------------------------------------------------------------------
    // Bus tasks, monitor and verdict
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        exp_q.push_back(v);
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask
    task automatic ping(input logic [4:0] e, input logic [1:0] x);
        @(posedge clk_in);
        ev <= e;
        xfer <= x;
        sel <= n;
        @(posedge clk_in);
        ev <= 5'h0;
        xfer <= 2'h0;
    endtask
    task automatic results();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        if (rd_d) chk(rdata_out, exp_q.pop_front());
        if (rx_stamp_valid_out) stamps.push_back(rx_stamp_out);
        rd_d <= rd_in;
    end
    initial begin
        #100us;
        fails++;
        results();
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        seed = 65;
        n = 4'h0;
        eng = '{default: 5'h0};
        usr = '{default: 5'h0};
        repeat (10) @(posedge clk_in);
        srst_in <= 1'b0;
        rd(8'h00, 32'h0480_0000);
        rd(8'hFC, 32'h0);
        wr(8'h00, 32'h0410_A01F);
        rd(8'h00, 32'h0490_A81F);
        for (int i = 0; i < 8; i++) begin
            m = modes[i];
            rsv = m == 3'h5 || m == 3'h6;
            c = rsv ? 3'h4 : m;
            wr(8'h00, {5'h0, m, 24'h10_8000});
            rd(8'h00, {5'h0, m, c, 21'h10_8800});
            rd(8'h04, rsv ? 32'h0 : 32'h8);
            wr(8'h04, 32'h8);
        end
        $display("test modes done");
        wr(8'h04, 32'hF80F_0000);
        ping(5'h1F, 2'h0);
        rd(8'h04, 32'hF80F_F800);
        #1 chk({31'h0, irq_out}, 32'h1);
        wr(8'h04, 32'h0);
        #1 chk({31'h0, irq_out}, 32'h0);
        wr(8'h04, 32'h0000_FFFF);
        rd(8'h04, 32'h0000_1000);
        wr(8'h04, 32'h1000_0000);
        #1 chk({31'h0, irq_out}, 32'h1);
        hold <= 1'b1;
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h0080_0800);
        hold <= 1'b0;
        repeat (3) @(posedge clk_in);
        rd(8'h00, 32'h0);
        wr(8'h00, 32'h0000_8000);
        #1 chk({31'h0, irq_out}, 32'h0);
        rd(8'h04, 32'h1000_0008);
        $display("test interrupts done");
        load <= 1'b1;
        wr(8'h00, 32'h0800_8000);
        load <= 1'b0;
        rd(8'h00, 32'h0800_8800);
        repeat (8) @(posedge clk_in);
        rd(8'h00, 32'h0000_8800);
        $display("test abort done");
        d = 16'($random(seed));
        wr(can_ctrl_pkg::OFS_DIRECTION, {16'h0, d});
        rd(can_ctrl_pkg::OFS_DIRECTION, {16'h0, d});
        for (int i = 0; i < 6; i++) begin
            n = 4'($random(seed));
            k = 1 + ($random(seed) & 3);
            repeat (k) ping(5'h0, d[n] ? 2'h2 : 2'h1);
            eng[n] = eng[n] + 5'(k);
            repeat (k - 1) wr(can_ctrl_pkg::OFS_ADVANCE, {16'h0, 16'h1 << n});
            usr[n] = usr[n] + 5'(k - 1);
            rd({2'h2, n, 2'h0}, {27'h0, eng[n]});
            rd({2'h1, n, 2'h0}, {19'h0, n, usr[n], 4'h0});
        end
        $display("test fifo pointers done");
        wr(8'h00, 32'h0010_8000);
        ping(5'h0, 2'h1);
        repeat (4) @(posedge clk_in);
        ping(5'h0, 2'h1);
        wr(8'h00, 32'h0000_8000);
        ping(5'h0, 2'h1);
        repeat (3) @(posedge clk_in);
        chk(32'(stamps.size()), 32'h2);
        chk({16'h0, stamps[1] - stamps[0]}, 32'h6);
        $display("test time stamp done");
        results();
    end
endmodule // can_mode_irq_fifo_pointer_logic_tb_top
